// ===== sim/rps_ctl_model.sv
`timescale 1ns/10ps

// Far-side controller: owns the transfer strobe and the select pins.
module rps_ctl_model (
  // Clock
  input wire logic   clk_sys,
  // Pins
  output logic       ioUpdate,
  output logic [2:0] selectPinGroup
);
  // Pins idle low until a scenario asks for more.
  initial
  begin
    ioUpdate       = 1'b0;
    selectPinGroup = 3'h0;
  end

  // One-cycle strobe; a rewritten code only lands with it.
  task automatic pulse();
    @(posedge clk_sys) ioUpdate <= 1'b1;
    @(posedge clk_sys) ioUpdate <= 1'b0;
  endtask

  // Pins change just after an edge and then hold level.
  task automatic pins(input logic [2:0] p);
    @(posedge clk_sys) selectPinGroup <= p;
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps

module testbench;
  import rps_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys, nrst, regWr, regRd, ioUpdate, sweepStatusPin;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, ramData, freqWord, v;
  logic [2:0]  selectPinGroup;
  logic [9:0]  ramAddr;
  logic [15:0] phaseWord;
  logic [13:0] ampWord;
  int          n_errors, compares;

  rps_ctl_model ctl_i (.clk_sys(clk_sys), .ioUpdate(ioUpdate), .selectPinGroup(selectPinGroup));
  rps_sequencer rps_sequencer_i (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ioUpdate(ioUpdate), .selectPinGroup(selectPinGroup),
    .sweepStatusPin(sweepStatusPin), .ramAddr(ramAddr), .ramData(ramData), .freqWord(freqWord),
    .phaseWord(phaseWord), .ampWord(ampWord));

  // Memory word is a pattern of its address, so any routing slip shows.
  function automatic logic [31:0] m(input logic [9:0] a);
    return {a, a, a, 2'h1};
  endfunction

  // Clock and one-cycle memory.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) ramData <= m(ramAddr);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys)
    begin
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
    end
    @(posedge clk_sys) regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys)
    begin
      regRd   <= 1'b1;
      regAddr <= a;
    end
    @(posedge clk_sys) regRd <= 1'b0;
    @(negedge clk_sys) d = regRdata;
  endtask

  task automatic prof(input int p, input logic [9:0] s, input logic [9:0] e, input logic [15:0] r, input int md);
    wr(8'h40 + 8'(16 * p), 32'(s));
    wr(8'h44 + 8'(16 * p), 32'(e));
    wr(8'h48 + 8'(16 * p), 32'(r));
    wr(8'h4c + 8'(16 * p), 32'(md));
  endtask

  // Bounded wait for an address, then compare.
  // The first look waits for a falling edge so a value still settling is never seen.
  task automatic wa(input logic [9:0] a, input int n);
    @(negedge clk_sys);
    for (int i = 0; i < n && ramAddr !== a; i++) @(negedge clk_sys);
    chk(32'(ramAddr), 32'(a));
  endtask

  // Sweep pin must stand high for exactly two cycles.
  task automatic sp();
    for (int i = 0; i < 40 && sweepStatusPin !== 1'b1; i++) @(negedge clk_sys);
    chk(32'(sweepStatusPin), 32'h1);
    @(negedge clk_sys) chk(32'(sweepStatusPin), 32'h1);
    @(negedge clk_sys) chk(32'(sweepStatusPin), 32'h0);
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the scenario lengths.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    nrst     = 1'b0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    regAddr  = 8'h00;
    regWdata = 32'h0000_0000;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h3c, v);
    chk(v, 32'h0);
    // Slow recirculate so the fetched word stands still per destination.
    prof(0, 10'h10, 10'h13, 16'h00ff, 3);
    rd(8'h44, v);
    chk(v, 32'h13);
    for (int d = 0; d < 4; d++)
    begin
      wr(8'h00, 32'(d));
      ctl_i.pulse();
      wa(10'h10, 8);
      repeat (4) @(negedge clk_sys);
      if (d == 0) chk(freqWord, m(10'h10));
      if (d[0]) chk(32'(phaseWord), 32'(m(10'h10) >> 16));
      if (d == 2) chk(32'(ampWord), 32'(m(10'h10) >> 18));
      if (d == 3) chk(32'(ampWord), 32'(m(10'h10) >> 2) & 32'h3fff);
    end
    // Recirculate with a fast rate.
    prof(0, 10'h10, 10'h13, 16'h0002, 3);
    ctl_i.pulse();
    wa(10'h10, 8);
    chk(32'(sweepStatusPin), 32'h0);
    wa(10'h11, 8);
    wa(10'h13, 20);
    sp();
    wa(10'h10, 8);
    // Internal continuous code 1000 over profiles 0 and 1.
    prof(1, 10'h20, 10'h22, 16'h0001, 0);
    wr(8'h00, 32'h0010_0000);
    ctl_i.pulse();
    wa(10'h10, 8);
    sp();
    wa(10'h20, 12);
    sp();
    wa(10'h10, 12);
    // Bidirectional on profile 0; upper pins must not matter.
    wr(8'h00, 32'h0);
    prof(0, 10'h10, 10'h13, 16'h0001, 1);
    ctl_i.pulse();
    wa(10'h10, 8);
    repeat (10) @(negedge clk_sys);
    chk(32'(ramAddr), 32'h10);
    chk(32'(sweepStatusPin), 32'h0);
    ctl_i.pins(3'h7);
    wa(10'h13, 20);
    repeat (2) @(negedge clk_sys);
    chk(32'(sweepStatusPin), 32'h1);
    ctl_i.pins(3'h6);
    wa(10'h10, 20);
    chk(32'(sweepStatusPin), 32'h1);
    ctl_i.pins(3'h7);
    wa(10'h11, 8);
    chk(32'(sweepStatusPin), 32'h0);
    ctl_i.pins(3'h6);
    wa(10'h10, 8);
    // Leave bidirectional, then select continuous bidirectional by pins.
    ctl_i.pins(3'h0);
    prof(0, 10'h10, 10'h13, 16'h0002, 3);
    // Slower steps keep each sweep level up long enough to be seen; no-dwell is set.
    prof(2, 10'h30, 10'h32, 16'h0004, 6);
    ctl_i.pulse();
    ctl_i.pins(3'h2);
    wa(10'h30, 8);
    chk(32'(sweepStatusPin), 32'h0);
    wa(10'h32, 12);
    repeat (2) @(negedge clk_sys);
    chk(32'(sweepStatusPin), 32'h1);
    wa(10'h30, 12);
    repeat (2) @(negedge clk_sys);
    chk(32'(sweepStatusPin), 32'h0);
    wa(10'h31, 8);
    ctl_i.pins(3'h0);
    wa(10'h10, 5);
    report_and_stop();
  end
endmodule

// ===== src/rps_map.svh
// ------------------------------------------------------------
// Waveform playback sequencer constants
// ------------------------------------------------------------
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

`define RPS_ADDR_W        10
`define RPS_RATE_W        16
`define RPS_NPROF         8
`define RPS_SWEEP_PULSE   2
// Register offsets (byte addresses).
`define RPS_OFF_CTRL      8'h00
`define RPS_OFF_STAT      8'h04
`define RPS_OFF_PROF      8'h40
`define RPS_OFF_PROF_END  8'hc0
// Per-profile word index within a profile slot.
`define RPS_PW_START      2'h0
`define RPS_PW_END        2'h1
`define RPS_PW_RATE       2'h2
`define RPS_PW_CFG        2'h3
// Control word one fields.
`define RPS_CTRL_CODE_LSB 17
`define RPS_CTRL_DEST_LSB 0
`define RPS_CODE_OFF      4'h0
`define RPS_CODE_INVALID  4'hf
// Profile config fields.
`define RPS_CFG_NODWELL   2
// Mode codes.
`define RPS_MODE_OFF      2'h0
`define RPS_MODE_BIDIR    2'h1
`define RPS_MODE_CBIDIR   2'h2
`define RPS_MODE_RECIRC   2'h3
`endif

// ===== src/rps_pkg.sv
`include "rps_map.svh"

package rps_pkg;
  // Playback mode held per profile.
  typedef enum logic [1:0] {
    RPS_OFF    = `RPS_MODE_OFF,
    RPS_BIDIR  = `RPS_MODE_BIDIR,
    RPS_CBIDIR = `RPS_MODE_CBIDIR,
    RPS_RECIRC = `RPS_MODE_RECIRC
  } rps_mode_t;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RUN  = 5'h02,
    S_END  = 5'h04,
    S_HOLD = 5'h08,
    S_HALT = 5'h10
  } rps_state_t;

  // Playback destination.
  typedef enum logic [1:0] {
    DST_FREQ  = 2'h0,
    DST_PHASE = 2'h1,
    DST_AMP   = 2'h2,
    DST_POLAR = 2'h3
  } rps_dest_t;
endpackage

// ===== src/rps_sequencer.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps

// ------------------------------------------------------------
// Waveform memory playback address sequencer
// ------------------------------------------------------------
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int ADDR_W = `RPS_ADDR_W,
  parameter int RATE_W = `RPS_RATE_W
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  // Controller pins
  input  wire logic              ioUpdate,
  input  wire logic [2:0]        selectPinGroup,
  output logic                   sweepStatusPin,
  // Waveform memory
  output logic      [ADDR_W-1:0] ramAddr,
  input  wire logic [31:0]       ramData,
  // Synthesizer parameters
  output logic      [31:0]       freqWord,
  output logic      [15:0]       phaseWord,
  output logic      [13:0]       ampWord
);
  localparam int NP = `RPS_NPROF;

  if (ADDR_W < 2 || ADDR_W > 16 || RATE_W < 1 || RATE_W > 32)
    $error("rps_sequencer: ADDR_W must be 2..16 and RATE_W 1..32");

  // ------------------------------------------------------------
  // Programming buffers and active copies
  // ------------------------------------------------------------
  logic [31:0]       shCtrl;
  logic [ADDR_W-1:0] shStart [NP];
  logic [ADDR_W-1:0] shEnd   [NP];
  logic [RATE_W-1:0] shRate  [NP];
  logic [2:0]        shCfg   [NP];
  logic [3:0]        acCode;
  rps_dest_t         acDest;
  logic [ADDR_W-1:0] acStart [NP];
  logic [ADDR_W-1:0] acEnd   [NP];
  logic [RATE_W-1:0] acRate  [NP];
  logic [2:0]        acCfg   [NP];

  logic       profHit;
  logic [2:0] profIdx;
  logic [1:0] profWord;
  logic [7:0] profOff;

  assign profHit  = regAddr >= `RPS_OFF_PROF && regAddr < `RPS_OFF_PROF_END;
  assign profOff  = regAddr - `RPS_OFF_PROF;
  assign profIdx  = profOff[6:4];
  assign profWord = profOff[3:2];

  // Software writes land in the buffers; nothing acts on them until a transfer.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      shCtrl <= '0;
      for (int i = 0; i < NP; i++)
      begin
        shStart[i] <= '0;
        shEnd[i]   <= '0;
        shRate[i]  <= '0;
        shCfg[i]   <= '0;
      end
    end
    else if (regWr && regAddr == `RPS_OFF_CTRL)
      shCtrl <= regWdata;
    else if (regWr && profHit)
    begin
      case (profWord)
        `RPS_PW_START: shStart[profIdx] <= regWdata[ADDR_W-1:0];
        `RPS_PW_END:   shEnd[profIdx]   <= regWdata[ADDR_W-1:0];
        `RPS_PW_RATE:  shRate[profIdx]  <= regWdata[RATE_W-1:0];
        default:       shCfg[profIdx]   <= regWdata[2:0];
      endcase
    end
  end

  // The transfer strobe copies every buffer into the working set at once.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      acCode <= `RPS_CODE_OFF;
      acDest <= DST_FREQ;
      for (int i = 0; i < NP; i++)
      begin
        acStart[i] <= '0;
        acEnd[i]   <= '0;
        acRate[i]  <= '0;
        acCfg[i]   <= '0;
      end
    end
    else if (ioUpdate)
    begin
      acCode <= shCtrl[`RPS_CTRL_CODE_LSB +: 4];
      acDest <= rps_dest_t'(shCtrl[`RPS_CTRL_DEST_LSB +: 2]);
      for (int i = 0; i < NP; i++)
      begin
        acStart[i] <= shStart[i];
        acEnd[i]   <= shEnd[i];
        acRate[i]  <= shRate[i];
        acCfg[i]   <= shCfg[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Start conditions
  // ------------------------------------------------------------
  rps_state_t state;
  rps_state_t next_state;
  rps_mode_t  curMode;
  logic [2:0] curProf;
  logic [2:0] next_prof;
  logic       dirUp;
  logic       next_dirUp;
  logic [ADDR_W-1:0] next_addr;
  logic [2:0] prevPins;
  logic       updPend;
  logic       intActive;
  logic       intCont;
  logic [2:0] lastProf;
  logic       pinChange;
  logic       startReq;
  rps_mode_t  selMode;
  logic [2:0] paramProf;
  logic [2:0] loadProf;
  logic [ADDR_W-1:0] startA;
  logic [ADDR_W-1:0] endA;
  logic       pin0;
  logic       pin0Rise;
  logic       swpSet;
  logic       swpClr;
  logic       swpPulse;

  rps_tmr_if #(.RATE_W(RATE_W)) tio ();

  rps_step_timer #(.RATE_W(RATE_W)) u_timer (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tio     (tio)
  );

  // Invalid code all-ones behaves as if internal control were off.
  assign intActive = acCode != `RPS_CODE_OFF && acCode != `RPS_CODE_INVALID;
  assign intCont   = acCode[3];
  assign lastProf  = intCont ? acCode[2:0] + 3'h1 : acCode[2:0];
  assign pin0      = selectPinGroup[0];
  assign pin0Rise  = pin0 && !prevPins[0];
  // Only the mode bits are looked at, so a set no-dwell bit changes nothing.
  assign selMode   = rps_mode_t'(acCfg[selectPinGroup][1:0]);
  // Bidirectional mode reads its range only from profile 0.
  assign paramProf = (intActive || selMode == RPS_BIDIR) ? 3'h0 : selectPinGroup;
  assign startA    = acStart[curProf];
  assign endA      = acEnd[curProf];

  // A bidirectional profile locks out the pins as profile selectors; internal
  // cycling ignores them entirely, so only the other modes restart on a change.
  assign pinChange = selectPinGroup != prevPins;
  assign startReq  = updPend || (pinChange && !intActive && curMode != RPS_BIDIR);

  // The transfer is acted on one clock later so the working set is settled.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      updPend  <= 1'b0;
      prevPins <= '0;
    end
    else
    begin
      updPend  <= ioUpdate;
      prevPins <= selectPinGroup;
    end
  end

  // ------------------------------------------------------------
  // Sequencing decisions
  // ------------------------------------------------------------
  // The no-dwell bit is never consulted: none of these modes honour it.
  always_comb
  begin
    next_state = state;
    next_addr  = ramAddr;
    next_dirUp = dirUp;
    next_prof  = curProf;
    loadProf   = curProf;
    tio.reload = 1'b0;
    swpSet     = 1'b0;
    swpClr     = 1'b0;
    swpPulse   = 1'b0;
    if (startReq)
    begin
      loadProf   = paramProf;
      next_prof  = paramProf;
      next_addr  = acStart[paramProf];
      next_dirUp = 1'b1;
      tio.reload = 1'b1;
      swpClr     = 1'b1;
      if (intActive)
        next_state = S_RUN;
      else if (selMode == RPS_BIDIR)
        next_state = S_HOLD;
      else if (selMode == RPS_OFF)
        next_state = S_IDLE;
      else
        next_state = S_RUN;
    end
    else
    begin
      case (state)
        S_RUN:
          if (curMode == RPS_BIDIR && dirUp != pin0)
          begin
            next_dirUp = pin0;
            tio.reload = 1'b1;
          end
          else if (tio.expire && dirUp)
          begin
            next_addr = ramAddr + 1'b1;
            if (next_addr == endA)
            begin
              if (intActive || curMode == RPS_RECIRC)
              begin
                swpPulse   = 1'b1;
                next_state = S_END;
              end
              else if (curMode == RPS_CBIDIR)
              begin
                swpSet     = 1'b1;
                next_dirUp = 1'b0;
              end
              else
              begin
                swpSet     = 1'b1;
                next_state = S_HOLD;
              end
            end
          end
          else if (tio.expire)
          begin
            next_addr = ramAddr - 1'b1;
            if (next_addr == startA)
            begin
              if (curMode == RPS_CBIDIR)
              begin
                swpClr     = 1'b1;
                next_dirUp = 1'b1;
              end
              else
                next_state = S_HOLD;
            end
          end
        S_END:
          if (tio.expire && intActive)
          begin
            if (curProf == lastProf && !intCont)
              next_state = S_HALT;
            else
            begin
              loadProf   = (curProf == lastProf) ? 3'h0 : curProf + 3'h1;
              next_prof  = loadProf;
              next_addr  = acStart[loadProf];
              tio.reload = 1'b1;
              next_state = S_RUN;
            end
          end
          else if (tio.expire)
          begin
            next_addr  = startA;
            next_state = S_RUN;
          end
        S_HOLD:
          if (ramAddr == endA && dirUp && !pin0)
          begin
            next_dirUp = 1'b0;
            tio.reload = 1'b1;
            next_state = S_RUN;
          end
          else if (ramAddr == startA && pin0)
          begin
            swpClr     = pin0Rise;
            next_dirUp = 1'b1;
            tio.reload = 1'b1;
            next_state = S_RUN;
          end
        default: next_state = state;
      endcase
    end
    tio.rate = acRate[loadProf];
  end

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state   <= S_IDLE;
      ramAddr <= '0;
      dirUp   <= 1'b1;
      curProf <= '0;
      curMode <= RPS_OFF;
    end
    else
    begin
      state   <= next_state;
      ramAddr <= next_addr;
      dirUp   <= next_dirUp;
      curProf <= next_prof;
      if (startReq)
        curMode <= intActive ? RPS_RECIRC : selMode;
    end
  end

  // ------------------------------------------------------------
  // Sweep status pin
  // ------------------------------------------------------------
  logic [1:0] swpCnt;
  logic       swpPulseMode;

  // A pulse holds the pin for a fixed count; a level holds it until cleared.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sweepStatusPin <= 1'b0;
      swpCnt         <= '0;
      swpPulseMode   <= 1'b0;
    end
    else if (swpClr)
    begin
      sweepStatusPin <= 1'b0;
      swpCnt         <= '0;
      swpPulseMode   <= 1'b0;
    end
    else if (swpSet)
      sweepStatusPin <= 1'b1;
    else if (swpPulse)
    begin
      sweepStatusPin <= 1'b1;
      swpCnt         <= 2'(`RPS_SWEEP_PULSE - 1);
      swpPulseMode   <= 1'b1;
    end
    else if (swpCnt != '0)
      swpCnt <= swpCnt - 1'b1;
    else if (swpPulseMode)
    begin
      sweepStatusPin <= 1'b0;
      swpPulseMode   <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Destination routing and register reads
  // ------------------------------------------------------------
  // Each word read from memory lands only in the chosen parameter fields.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      freqWord  <= '0;
      phaseWord <= '0;
      ampWord   <= '0;
    end
    else
    begin
      case (acDest)
        DST_FREQ:  freqWord  <= ramData;
        DST_PHASE: phaseWord <= ramData[31:16];
        DST_AMP:   ampWord   <= ramData[31:18];
        DST_POLAR:
        begin
          phaseWord <= ramData[31:16];
          ampWord   <= ramData[15:2];
        end
        default: freqWord <= freqWord;
      endcase
    end
  end

  // Control and profile reads return the buffers, so software sees what it wrote before a transfer; status reads return live state.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      regRdata <= '0;
    else if (!regRd)
      regRdata <= '0;
    else if (regAddr == `RPS_OFF_CTRL)
      regRdata <= shCtrl;
    else if (regAddr == `RPS_OFF_STAT)
      regRdata <= {sweepStatusPin, 2'h0, state, 1'b0, curProf, dirUp, curMode, 1'b0,
                   16'(ramAddr)};
    else if (profHit)
    begin
      case (profWord)
        `RPS_PW_START: regRdata <= 32'(shStart[profIdx]);
        `RPS_PW_END:   regRdata <= 32'(shEnd[profIdx]);
        `RPS_PW_RATE:  regRdata <= 32'(shRate[profIdx]);
        default:       regRdata <= 32'(shCfg[profIdx]);
      endcase
    end
    else
      regRdata <= '0;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_pulse_cause;
    swpPulse ##1 !startReq;
  endsequence
  sequence s_pulse_shape;
    sweepStatusPin [*2] ##1 (!sweepStatusPin || startReq || $past(swpSet || swpPulse));
  endsequence
  property p_pulse_two;
    s_pulse_cause |-> s_pulse_shape;
  endproperty
  a_pulse_two: assert property (p_pulse_two) else $error("sweep pulse not two clocks");

  property p_start_clear;
    startReq |=> !sweepStatusPin && ramAddr == acStart[curProf];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not load and clear");

  property p_step_one;
    (state == S_RUN && tio.expire && !startReq && !(curMode == RPS_BIDIR && dirUp != pin0))
      |=> (ADDR_W'(ramAddr - $past(ramAddr)) == 1) || (ADDR_W'($past(ramAddr) - ramAddr) == 1);
  endproperty
  a_step_one: assert property (p_step_one) else $error("address step not one");

  property p_reverse;
    (state == S_RUN && curMode == RPS_BIDIR && dirUp != pin0 && !startReq)
      |=> dirUp == $past(pin0) && ramAddr == $past(ramAddr) && !tio.expire;
  endproperty
  a_reverse: assert property (p_reverse) else $error("direction reversal wrong");

  property p_cbidir_end;
    (state == S_RUN && curMode == RPS_CBIDIR && swpSet && !startReq) |=> sweepStatusPin && !dirUp;
  endproperty
  a_cbidir_end: assert property (p_cbidir_end) else $error("no reversal at end");

  property p_int_wrap;
    (state == S_END && intActive && intCont && curProf == lastProf && tio.expire && !startReq)
      |=> curProf == 3'h0 && state == S_RUN;
  endproperty
  a_int_wrap: assert property (p_int_wrap) else $error("internal cycle did not wrap");

  property p_bidir_prof0;
    (state != S_IDLE && curMode == RPS_BIDIR) |-> curProf == 3'h0;
  endproperty
  a_bidir_prof0: assert property (p_bidir_prof0) else $error("bidirectional off profile 0");

  property p_hold_end;
    (state == S_HOLD && ramAddr == endA && ramAddr != startA && pin0 && !startReq)
      |=> state == S_HOLD && ramAddr == $past(ramAddr);
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("left end while pin high");

  property p_bidir_keep;
    (curMode == RPS_BIDIR && sweepStatusPin && !startReq && !(state == S_HOLD && pin0Rise))
      |=> sweepStatusPin;
  endproperty
  a_bidir_keep: assert property (p_bidir_keep) else $error("sweep pin dropped early");
endmodule

// ===== src/rps_step_timer.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Step timer: one expire pulse every rate clocks
// ------------------------------------------------------------
module rps_step_timer #(
  parameter int RATE_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  rps_tmr_if.tmr   tio
);
  logic [RATE_W-1:0] count;
  logic [RATE_W-1:0] period;
  logic              expireQ;

  if (RATE_W < 1) $error("rps_step_timer: RATE_W must be at least 1");

  assign tio.expire = expireQ;

  // A rate of zero runs at one step per clock rather than stalling forever.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      count   <= '0;
      period  <= '0;
      expireQ <= 1'b0;
    end
    else if (tio.reload)
    begin
      period  <= (tio.rate == '0) ? '0 : tio.rate - 1'b1;
      count   <= (tio.rate == '0) ? '0 : tio.rate - 1'b1;
      expireQ <= 1'b0;
    end
    else if (count == '0)
    begin
      count   <= period;
      expireQ <= 1'b1;
    end
    else
    begin
      count   <= count - 1'b1;
      expireQ <= 1'b0;
    end
  end
endmodule

// ===== src/rps_tmr_if.sv
`timescale 1ns/10ps

// Link between the sequencer and its step timer.
interface rps_tmr_if #(parameter int RATE_W = 16);
  logic              reload;
  logic [RATE_W-1:0] rate;
  logic              expire;

  modport ctl (output reload, output rate, input expire);
  modport tmr (input reload, input rate, output expire);
endinterface
